// file: design/dac_port_sync.sv
// sample port control, clock synchronizer and spi registers
// Summary of operation
// - port A enable clear: receivers off, port A sample reads zero
// - port B enable clear: receivers off, port B sample reads zero
// - single-port select set: dac code comes from port B only
// - single-port select clear: dual mode, both ports feed the code
// - update enable clear: dac code forced to mid-scale
// - update enable set: received samples pass through per port mode
// - reset clears port control: receivers off, dual mode, muted
// - dual mode: port A sample of each pair leaves before port B
// - two comparators watch forwarded clock against sample divider
// - automatic mode: multiplexer phase follows slow clock drift
// - comparator outputs readable as 8-bit phase detector result
// - phase select sets mux phase; automatic mode updates it itself
// - manual mode stops tracking; written phase select is applied
// - dual-mode result to phase select mapping table
// - single-mode result to phase select mapping table
// - reset clears both synchronizer registers: automatic, phase 00
// - no forwarded clock: mid-scale output, sample path held reset
// - samples are two's complement, so mid-scale is code zero
`timescale 1ns/1ns
`default_nettype none
module dac_port_sync
  import dac_port_pkg::*;
#(
  parameter int WIDTH = SAMPLE_BITS
)
(
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic spi_cs_n,
  input wire logic spi_sck,
  input wire logic spi_sdi,
  output logic spi_sdo,
  input wire logic forwarded_sample_clock,
  input wire logic converter_sample_clock,
  input wire logic forwarded_clock_rx_enable,
  input wire logic [WIDTH-1:0] port_a_lanes,
  input wire logic [WIDTH-1:0] port_b_lanes,
  output logic port_a_rx_power,
  output logic port_b_rx_power,
  output logic forwarded_clock_present,
  output logic [1:0] mux_phase,
  output logic [WIDTH-1:0] dac_code
);
  // spi slave
  logic sck_prev_reg;
  logic [4:0] bit_cnt_reg;
  logic [4:0] bit_cnt_next;
  logic [15:0] shift_in_reg;
  logic [7:0] sdo_shift_reg;
  logic [7:0] sdo_shift_next;
  logic spi_sdo_reg;
  logic sck_rise;
  logic sck_fall;
  logic [7:0] head_byte;
  logic wr_fire;
  logic [6:0] wr_addr;
  logic [7:0] wr_data;
  logic [7:0] rd_data;

  // register state
  port_ctrl_t port_ctrl_reg;
  port_ctrl_t port_ctrl_next;
  phase_ctrl_t phase_ctrl_reg;
  phase_ctrl_t phase_ctrl_next;
  logic [7:0] phase_status_reg;
  logic [7:0] phase_status_next;
  logic wr_port;
  logic wr_phase;

  // clock edges and presence
  logic fwd_prev_reg;
  logic conv_prev_reg;
  logic fwd_edge;
  logic conv_edge;
  logic [7:0] loss_cnt_reg;
  logic [7:0] loss_cnt_next;
  logic present_reg;
  logic present_next;
  logic [1:0] div_cnt_reg;
  logic [1:0] div_cnt_next;

  // comparators and table
  logic [2:0] lag [2];
  logic [1:0] best_phase;
  logic best_known;
  logic auto_update;

  // sample path
  logic [WIDTH-1:0] lane_a;
  logic [WIDTH-1:0] lane_b;
  logic [WIDTH-1:0] pair_a_reg;
  logic [WIDTH-1:0] pair_b_reg;
  logic [WIDTH-1:0] hold_b_reg;
  logic [WIDTH-1:0] pair_a_next;
  logic [WIDTH-1:0] pair_b_next;
  logic [WIDTH-1:0] hold_b_next;
  logic [WIDTH-1:0] dac_reg;
  logic [WIDTH-1:0] dac_next;
  logic [1:0] slot;
  logic first_slot;
  logic mute;

  // spi framing: rw bit, 7-bit address, 8-bit data, msb first
  assign sck_rise = !spi_cs_n && spi_sck && !sck_prev_reg;
  assign sck_fall = !spi_cs_n && !spi_sck && sck_prev_reg;
  assign head_byte = {shift_in_reg[6:0], spi_sdi};
  assign wr_fire = sck_rise && bit_cnt_reg == SPI_FRAME_LAST &&
                   !shift_in_reg[14];
  assign wr_addr = shift_in_reg[13:7];
  assign wr_data = {shift_in_reg[6:0], spi_sdi};
  assign bit_cnt_next = spi_cs_n ? 5'h00 :
                        sck_rise ? 5'(bit_cnt_reg + 5'h01) : bit_cnt_reg;
  assign sdo_shift_next =
    (sck_rise && bit_cnt_reg == SPI_HEAD_LAST && head_byte[7]) ?
      rd_data :
    (sck_fall && bit_cnt_reg > SPI_HEAD_LAST) ?
      {sdo_shift_reg[6:0], 1'b0} : sdo_shift_reg;
  assign spi_sdo = spi_sdo_reg;

  // read mux keyed on the header's address field
  assign rd_data =
    head_byte[6:0] == PORT_CTRL_ADDR ? {4'h0, port_ctrl_reg} :
    head_byte[6:0] == PHASE_CTRL_ADDR ? {5'h00, phase_ctrl_reg} :
    head_byte[6:0] == PHASE_STAT_ADDR ? phase_status_reg :
    8'h00;

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      sck_prev_reg <= 1'b0;
      bit_cnt_reg <= 5'h00;
      shift_in_reg <= 16'h0000;
      sdo_shift_reg <= 8'h00;
      spi_sdo_reg <= 1'b0;
    end else begin
      sck_prev_reg <= spi_sck;
      bit_cnt_reg <= bit_cnt_next;
      if (sck_rise) begin
        shift_in_reg <= {shift_in_reg[14:0], spi_sdi};
      end
      sdo_shift_reg <= sdo_shift_next;
      if (sck_fall && bit_cnt_reg > SPI_HEAD_LAST) begin
        spi_sdo_reg <= sdo_shift_reg[7];
      end else if (spi_cs_n) begin
        spi_sdo_reg <= 1'b0;
      end
    end
  end

  // register writes
  assign wr_port = wr_fire && wr_addr == PORT_CTRL_ADDR;
  assign wr_phase = wr_fire && wr_addr == PHASE_CTRL_ADDR;
  assign port_ctrl_next = wr_port ? port_ctrl_t'({
    wr_data[DATA_EN_BIT], wr_data[SINGLE_PORT_BIT],
    wr_data[B_EN_BIT], wr_data[A_EN_BIT]}) : port_ctrl_reg;
  assign auto_update = !phase_ctrl_reg.manual_phase_mode &&
                       best_known && present_reg;
  always_comb begin
    phase_ctrl_next = phase_ctrl_reg;
    if (wr_phase) begin
      phase_ctrl_next.manual_phase_mode = wr_data[MANUAL_BIT];
    end
    if (wr_phase && wr_data[MANUAL_BIT]) begin
      phase_ctrl_next.mux_phase_select =
        wr_data[PHASE_SEL_LSB +: 2];
    end else if (auto_update) begin
      phase_ctrl_next.mux_phase_select = best_phase;
    end
  end
  // status follows comparators every cycle, no read side effect
  assign phase_status_next = {1'b0, lag[1], 1'b0, lag[0]};

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      port_ctrl_reg <= port_ctrl_t'(PORT_CTRL_RESET[3:0]);
      phase_ctrl_reg <= phase_ctrl_t'(PHASE_CTRL_RESET[2:0]);
      phase_status_reg <= PHASE_STAT_RESET;
    end else begin
      port_ctrl_reg <= port_ctrl_next;
      phase_ctrl_reg <= phase_ctrl_next;
      phase_status_reg <= phase_status_next;
    end
  end

  // clock edge detection; both clocks are slower than mclk here
  assign fwd_edge = forwarded_sample_clock != fwd_prev_reg;
  assign conv_edge = converter_sample_clock && !conv_prev_reg;
  assign loss_cnt_next = (fwd_edge || !forwarded_clock_rx_enable) ? 8'h00 :
    (loss_cnt_reg != 8'(LOSS_CYCLES)) ? 8'(loss_cnt_reg + 8'h01) :
    loss_cnt_reg;
  assign present_next = forwarded_clock_rx_enable &&
                        loss_cnt_next != 8'(LOSS_CYCLES);
  assign div_cnt_next = conv_edge ? 2'(div_cnt_reg + 2'h1) : div_cnt_reg;

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      fwd_prev_reg <= 1'b0;
      conv_prev_reg <= 1'b0;
      loss_cnt_reg <= 8'h00;
      present_reg <= 1'b0;
      div_cnt_reg <= 2'h0;
    end else begin
      fwd_prev_reg <= forwarded_sample_clock;
      conv_prev_reg <= converter_sample_clock;
      loss_cnt_reg <= loss_cnt_next;
      present_reg <= present_next;
      div_cnt_reg <= div_cnt_next;
    end
  end

  // two comparators, referenced to opposite divider phases
  for (genvar i = 0; i < 2; i++) begin : g_cmp
    phase_comparator u_cmp (
      .mclk(mclk),
      .reset_n(reset_n),
      .clear(!present_reg),
      .ref_edge(conv_edge && div_cnt_reg == 2'(2 * i)),
      .clk_edge(fwd_edge && forwarded_sample_clock),
      .lag(lag[i])
    );
  end

  phase_select_table u_table (
    .phase_result(phase_status_reg),
    .single_port(port_ctrl_reg.single_port_select),
    .best_phase(best_phase),
    .known(best_known)
  );

  // sample path
  assign lane_a = port_ctrl_reg.port_a_rx_enable ?
                  port_a_lanes : '0;
  assign lane_b = port_ctrl_reg.port_b_rx_enable ?
                  port_b_lanes : '0;
  assign mute = !port_ctrl_reg.data_en || !present_reg;
  assign slot = 2'(div_cnt_reg - phase_ctrl_reg.mux_phase_select);
  assign first_slot = !slot[0];
  assign pair_a_next = !present_reg ? '0 :
                       fwd_edge ? lane_a : pair_a_reg;
  assign pair_b_next = !present_reg ? '0 :
                       fwd_edge ? lane_b : pair_b_reg;
  assign hold_b_next = (conv_edge && first_slot) ? pair_b_reg : hold_b_reg;
  // two's complement, so mid-scale is simply code zero
  always_comb begin
    dac_next = dac_reg;
    if (mute) begin
      dac_next = MID_SCALE[WIDTH-1:0];
    end else if (conv_edge && port_ctrl_reg.single_port_select) begin
      if (first_slot) begin
        dac_next = pair_b_reg;
      end
    end else if (conv_edge) begin
      dac_next = first_slot ? pair_a_reg : hold_b_reg;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      pair_a_reg <= '0;
      pair_b_reg <= '0;
      hold_b_reg <= '0;
      dac_reg <= '0;
    end else begin
      pair_a_reg <= pair_a_next;
      pair_b_reg <= pair_b_next;
      hold_b_reg <= hold_b_next;
      dac_reg <= dac_next;
    end
  end

  assign dac_code = dac_reg;
  assign port_a_rx_power = port_ctrl_reg.port_a_rx_enable;
  assign port_b_rx_power = port_ctrl_reg.port_b_rx_enable;
  assign forwarded_clock_present = present_reg;
  assign mux_phase = phase_ctrl_reg.mux_phase_select;

  // checks
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!reset_n);

  chk_port_a_zero: assert property (
    !port_ctrl_reg.port_a_rx_enable && present_reg && fwd_edge
    |=> pair_a_reg == '0)
    else $error("port A not zero while disabled");
  chk_port_b_zero: assert property (
    !port_ctrl_reg.port_b_rx_enable && present_reg && fwd_edge
    |=> pair_b_reg == '0)
    else $error("port B not zero while disabled");
  chk_mute_mid_scale: assert property (
    !port_ctrl_reg.data_en |=> dac_code == MID_SCALE[WIDTH-1:0])
    else $error("output not mid-scale while muted");
  chk_lost_clock_mute: assert property (
    !present_reg |=> dac_code == '0 && pair_a_reg == '0)
    else $error("sample path active without clock");
  chk_single_port_b: assert property (
    !mute && conv_edge && port_ctrl_reg.single_port_select && first_slot
    |=> dac_code == $past(pair_b_reg))
    else $error("single mode did not take port B");
  chk_dual_a_first: assert property (
    !mute && conv_edge && !port_ctrl_reg.single_port_select && first_slot
    |=> dac_code == $past(pair_a_reg))
    else $error("dual mode did not lead with port A");
  chk_auto_phase_track: assert property (
    auto_update && !wr_phase |=> mux_phase == $past(best_phase))
    else $error("automatic phase did not follow table");
  chk_manual_phase_hold: assert property (
    phase_ctrl_reg.manual_phase_mode && !wr_phase |=> $stable(mux_phase))
    else $error("manual phase changed without a write");
  chk_auto_ignores_write: assert property (
    wr_phase && !wr_data[MANUAL_BIT] && !auto_update
    |=> $stable(mux_phase))
    else $error("phase write took effect in automatic mode");
  chk_status_refresh: assert property (
    ##1 phase_status_reg == {1'b0, $past(lag[1]), 1'b0, $past(lag[0])})
    else $error("phase status not refreshed");
  chk_dual_b_second: assert property (
    !mute && conv_edge && !port_ctrl_reg.single_port_select && !first_slot
    |=> dac_code == $past(hold_b_reg))
    else $error("dual mode did not follow with port B");
  chk_single_odd_hold: assert property (
    !mute && conv_edge && port_ctrl_reg.single_port_select && !first_slot
    |=> $stable(dac_code))
    else $error("single mode took a second sample");
  chk_no_clock_clear: assert property (
    !present_reg |=> lag[0] == 3'h0 && lag[1] == 3'h0)
    else $error("comparators not held while clock absent");
  chk_rx_off_absent: assert property (
    !forwarded_clock_rx_enable |=> !forwarded_clock_present)
    else $error("clock reported present with receiver off");

  cov_dual_stream: cover property (
    !mute && conv_edge && !port_ctrl_reg.single_port_select);
  cov_single_stream: cover property (
    !mute && conv_edge && port_ctrl_reg.single_port_select);
  cov_manual_write: cover property (wr_phase && wr_data[MANUAL_BIT]);
  cov_clock_loss: cover property (present_reg ##1 !present_reg);
endmodule : dac_port_sync
`default_nettype wire

// file: design/dac_port_pkg.sv
// shared constants and types for the dac sample input port block
package dac_port_pkg;
  localparam logic [6:0] PORT_CTRL_ADDR = 7'h04;
  localparam logic [6:0] PHASE_CTRL_ADDR = 7'h05;
  localparam logic [6:0] PHASE_STAT_ADDR = 7'h06;
  localparam logic [7:0] PORT_CTRL_RESET = 8'h00;
  localparam logic [7:0] PHASE_CTRL_RESET = 8'h00;
  localparam logic [7:0] PHASE_STAT_RESET = 8'h00;
  localparam int A_EN_BIT = 0;
  localparam int B_EN_BIT = 1;
  localparam int SINGLE_PORT_BIT = 2;
  localparam int DATA_EN_BIT = 3;
  localparam int PHASE_SEL_LSB = 0;
  localparam int MANUAL_BIT = 2;
  localparam int LAG0_LSB = 0;
  localparam int LAG1_LSB = 4;
  localparam int SAMPLE_BITS = 16;
  localparam logic [15:0] MID_SCALE = 16'h0000;
  localparam logic [2:0] PHASE_LAG_MAX = 3'h5;
  localparam logic [4:0] SPI_HEAD_LAST = 5'h07;
  localparam logic [4:0] SPI_FRAME_LAST = 5'h0f;
  localparam int CLK_PERIOD_NS = 100;
  localparam int LOSS_TIME_NS = 400;
  localparam int LOSS_CYCLES =
    (LOSS_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef struct packed {
    logic data_en;
    logic single_port_select;
    logic port_b_rx_enable;
    logic port_a_rx_enable;
  } port_ctrl_t;

  typedef struct packed {
    logic manual_phase_mode;
    logic [1:0] mux_phase_select;
  } phase_ctrl_t;
endpackage : dac_port_pkg

// file: design/phase_comparator.sv
// one phase comparator: lag from divider edge to forwarded clock edge
`timescale 1ns/1ns
`default_nettype none
module phase_comparator
  import dac_port_pkg::*;
(
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic clear,
  input wire logic ref_edge,
  input wire logic clk_edge,
  output logic [2:0] lag
);
  logic armed_reg;
  logic armed_next;
  logic [2:0] count_reg;
  logic [2:0] count_next;
  logic [2:0] lag_reg;
  logic [2:0] lag_next;

  // count saturates so a missing clock edge cannot wrap the result
  assign armed_next = clear ? 1'b0 : ref_edge ? 1'b1 :
                      clk_edge ? 1'b0 : armed_reg;
  assign count_next = (clear || ref_edge) ? 3'h0 :
                      (armed_reg && count_reg != PHASE_LAG_MAX) ?
                      3'(count_reg + 3'h1) : count_reg;
  assign lag_next = clear ? 3'h0 :
                    (clk_edge && armed_reg) ? count_reg : lag_reg;
  assign lag = lag_reg;

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      armed_reg <= 1'b0;
      count_reg <= 3'h0;
      lag_reg <= 3'h0;
    end else begin
      armed_reg <= armed_next;
      count_reg <= count_next;
      lag_reg <= lag_next;
    end
  end
endmodule : phase_comparator
`default_nettype wire

// file: design/phase_select_table.sv
// maps a comparator result to the best multiplexer phase per port mode
`timescale 1ns/1ns
`default_nettype none
module phase_select_table
  import dac_port_pkg::*;
(
  input wire logic [7:0] phase_result,
  input wire logic single_port,
  output logic [1:0] best_phase,
  output logic known
);
  logic [1:0] dual_phase;
  logic [1:0] single_phase;

  // unlisted results leave the phase alone rather than guess
  always_comb begin
    known = 1'b1;
    dual_phase = 2'b00;
    single_phase = 2'b00;
    unique case (phase_result)
      8'h03, 8'h04, 8'h05, 8'h15, 8'h25: begin
        dual_phase = 2'b10;
        single_phase = 2'b00;
      end
      8'h35, 8'h45, 8'h55, 8'h54, 8'h53: begin
        dual_phase = 2'b00;
        single_phase = 2'b10;
      end
      8'h52, 8'h51, 8'h50, 8'h40, 8'h30: begin
        dual_phase = 2'b01;
        single_phase = 2'b10;
      end
      8'h20, 8'h10, 8'h00, 8'h01, 8'h02: begin
        dual_phase = 2'b11;
        single_phase = 2'b00;
      end
      default: known = 1'b0;
    endcase
  end

  assign best_phase = single_port ? single_phase : dual_phase;
endmodule : phase_select_table
`default_nettype wire

// file: bench/sample_host.sv
// host model: forwarded clock, converter clock and both sample ports
`timescale 1ns/1ns
`default_nettype none
module sample_host (
  input wire logic mclk,
  input wire logic run,
  input wire logic single,
  input wire logic slip,
  input wire logic [15:0] base,
  output logic fwd_clk,
  output logic conv_clk,
  output logic [15:0] lane_a,
  output logic [15:0] lane_b
);
  logic [2:0] cnt;
  logic [15:0] k;
  logic [15:0] pair_a;
  logic run_q;
  logic slip_q;
  assign pair_a = base + {k[14:0], 1'b0};
  initial begin
    run_q = 1'b0;
    slip_q = 1'b0;
    fwd_clk = 1'b0;
    conv_clk = 1'b0;
    cnt = 3'h0;
    k = 16'h0000;
    lane_a = 16'h0000;
    lane_b = 16'h0000;
  end
  // taken on the rising edge so falling-edge bench writes cannot race
  always @(posedge mclk) begin
    run_q <= run;
    slip_q <= slip;
  end
  always @(negedge mclk) begin
    cnt <= cnt + 3'h1;
    conv_clk <= ~conv_clk;
    // forwarded clock stands still while the host is idle
    // a slip drops one toggle, moving the clock by half a period
    if (run_q && cnt[0] && !slip_q) begin
      fwd_clk <= ~fwd_clk;
    end
    if (cnt == 3'h7) begin
      k <= k + 16'h0001;
    end
    // unused port shows a changing even pattern, never a real sample
    lane_a <= single ? ~lane_a & 16'hfffe : pair_a;
    lane_b <= pair_a | 16'h0001;
  end
endmodule : sample_host
`default_nettype wire

// file: bench/tb.sv
// self-checking testbench for the dac sample port block
`timescale 1ns/1ns
`default_nettype none
module tb;
  import dac_port_pkg::*;
  localparam int LIMIT = 20000;
  logic mclk, reset_n, spi_cs_n, spi_sck, spi_sdi, spi_sdo;
  logic rx_en, run, slip, fwd, conv, a_pwr, b_pwr, present;
  logic [15:0] lane_a, lane_b, dac_code, base, prev, odd_exp;
  logic [1:0] mux_phase, p;
  logic [7:0] ctrl, rd, st;
  logic [2:0] tv;
  logic [7:0] modes [4] = '{8'h0a, 8'h0e, 8'h0c, 8'h0f};
  int n_errors, comparisons, settle, evens, odds, seed, hits;

  dac_port_sync i_dut (.mclk, .reset_n, .spi_cs_n, .spi_sck, .spi_sdi,
    .spi_sdo, .forwarded_sample_clock(fwd), .converter_sample_clock(conv),
    .forwarded_clock_rx_enable(rx_en), .port_a_lanes(lane_a),
    .port_b_lanes(lane_b), .port_a_rx_power(a_pwr),
    .port_b_rx_power(b_pwr), .forwarded_clock_present(present),
    .mux_phase, .dac_code);
  sample_host i_host (.mclk, .run, .single(ctrl[2]), .slip, .base,
    .fwd_clk(fwd), .conv_clk(conv), .lane_a, .lane_b);

  always #50 mclk = ~mclk;

  task automatic wrap_up();
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : wrap_up

  task automatic chk(input string what, input logic [15:0] exp,
                     input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // one 16-bit frame; sck high and low two cycles each
  task automatic spi(input logic rw, input logic [6:0] a, input logic [7:0] d);
    logic [15:0] f;
    f = {rw, a, d};
    spi_cs_n = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      spi_sdi = f[i];
      spi_sck = 1'b0;
      repeat (2) @(negedge mclk);
      if (i < 8) rd[i] = spi_sdo;
      spi_sck = 1'b1;
      repeat (2) @(negedge mclk);
    end
    spi_sck = 1'b0;
    @(negedge mclk);
    spi_cs_n = 1'b1;
    @(negedge mclk);
  endtask : spi

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    // stream checks pause while the write lands before the frame ends
    settle = -80;
    spi(1'b0, a, d);
    if (a == PORT_CTRL_ADDR) ctrl = d;
    settle = 0;
  endtask : wr

  task automatic rdchk(input string what, input logic [6:0] a,
                       input logic [7:0] exp);
    spi(1'b1, a, 8'h00);
    chk(what, {8'h00, exp}, {8'h00, rd});
  endtask : rdchk

  function automatic logic [2:0] best(input logic [7:0] s, input logic sp);
    case (s)
      8'h03, 8'h04, 8'h05, 8'h15, 8'h25: best = sp ? 3'h4 : 3'h6;
      8'h35, 8'h45, 8'h55, 8'h54, 8'h53: best = sp ? 3'h6 : 3'h4;
      8'h52, 8'h51, 8'h50, 8'h40, 8'h30: best = sp ? 3'h6 : 3'h5;
      8'h20, 8'h10, 8'h00, 8'h01, 8'h02: best = sp ? 3'h4 : 3'h7;
      default: best = 3'h0;
    endcase
  endfunction : best

  task automatic auto_phase();
    spi(1'b1, PHASE_STAT_ADDR, 8'h00);
    st = rd;
    tv = best(st, ctrl[2]);
    chk("status form", 16'h0000, {8'h00, st & 8'h88});
    spi(1'b1, PHASE_CTRL_ADDR, 8'h00);
    chk("phase out", {14'h0, rd[1:0]}, {14'h0, mux_phase});
    chk("mode bit", 16'h0000, {15'h0, rd[2]});
    if (tv[2]) begin
      hits++;
      chk("auto phase", 16'(tv[1:0]), 16'(rd[1:0]));
    end
  endtask : auto_phase

  task automatic rst_chk();
    ctrl = 8'h00;
    settle = 0;
    chk("reset dac", MID_SCALE, dac_code);
    chk("reset phase", 16'h0000, 16'(mux_phase));
    rdchk("port rst", PORT_CTRL_ADDR, PORT_CTRL_RESET);
    rdchk("phase rst", PHASE_CTRL_ADDR, PHASE_CTRL_RESET);
  endtask : rst_chk

  // reference model of the output stream, checked every cycle
  always @(negedge mclk) begin
    if (reset_n && settle > 16) begin
      chk("rx power", 16'(ctrl[1:0]), 16'({b_pwr, a_pwr}));
      chk("present", 16'(run & rx_en), 16'(present));
      if (!ctrl[3] || !run || !rx_en) begin
        chk("mute", MID_SCALE, dac_code);
      end else if (ctrl[2]) begin
        odd_exp = ctrl[1] ? dac_code | 16'h1 : 16'h0;
        chk("single", odd_exp, dac_code);
      end else if (!ctrl[0]) begin
        odd_exp = dac_code[0] ? dac_code : 16'h0;
        chk("a off", odd_exp, dac_code);
      end else if (dac_code !== prev) begin
        if (dac_code[0]) begin
          odds++;
          chk("order", dac_code - 16'h0001, prev);
        end else begin
          evens++;
        end
      end
    end
    prev = dac_code;
    settle++;
  end

  initial begin
    repeat (LIMIT) @(posedge mclk);
    n_errors++;
    wrap_up();
  end

  initial begin
    mclk = 1'b0;
    reset_n = 1'b0;
    spi_cs_n = 1'b1;
    spi_sck = 1'b0;
    spi_sdi = 1'b0;
    rx_en = 1'b0;
    run = 1'b0;
    slip = 1'b0;
    hits = 0;
    ctrl = 8'h00;
    prev = 16'h0000;
    settle = 0;
    n_errors = 0;
    comparisons = 0;
    evens = 0;
    odds = 0;
    seed = 32'hb50f2e3e;
    base = 16'($random(seed)) & 16'hfffe;
    repeat (12) @(negedge mclk);
    reset_n = 1'b1;
    rst_chk();
    rdchk("unmapped", 7'h7f, 8'h00);
    rx_en = 1'b1;
    run = 1'b1;
    settle = 0;
    // shortened stand-in for the settling wait before data flows
    repeat (40) @(negedge mclk);
    wr(PORT_CTRL_ADDR, 8'h03);
    repeat (40) @(negedge mclk);
    wr(PORT_CTRL_ADDR, 8'h0b);
    rdchk("port rb", PORT_CTRL_ADDR, 8'h0b);
    repeat (200) @(negedge mclk);
    chk("both ports", 16'h1, {15'h0, evens > 0 && odds > 0});
    auto_phase();
    foreach (modes[m]) begin
      wr(PORT_CTRL_ADDR, modes[m]);
      // status alternates between a listed and an unlisted result
      slip = 1'b1;
      repeat (2) @(negedge mclk);
      slip = 1'b0;
      repeat (100) @(negedge mclk);
      auto_phase();
    end
    wr(PHASE_STAT_ADDR, 8'hff);
    auto_phase();
    chk("table hit", 16'h0001, 16'(hits > 0));
    rx_en = 1'b0;
    settle = 0;
    repeat (40) @(negedge mclk);
    rx_en = 1'b1;
    run = 1'b0;
    settle = 0;
    repeat (40) @(negedge mclk);
    run = 1'b1;
    settle = 0;
    repeat (60) @(negedge mclk);
    for (int j = 0; j < 4; j++) begin
      tv = 3'($random(seed));
      wr(PHASE_CTRL_ADDR, {6'h01, tv[1:0]});
      chk("manual", {14'h0, tv[1:0]}, {14'h0, mux_phase});
      rdchk("manual rb", PHASE_CTRL_ADDR, {6'h01, tv[1:0]});
    end
    spi(1'b1, PHASE_STAT_ADDR, 8'h00);
    tv = best(rd, ctrl[2]);
    p = tv[2] ? tv[1:0] : mux_phase;
    wr(PHASE_CTRL_ADDR, {6'h01, p});
    chk("host phase", {14'h0, p}, {14'h0, mux_phase});
    wr(PHASE_CTRL_ADDR, {6'h00, ~p});
    chk("auto write", {14'h0, p}, {14'h0, mux_phase});
    // receiver off so tracking cannot move the phase before the readback
    rx_en = 1'b0;
    reset_n = 1'b0;
    repeat (2) @(negedge mclk);
    reset_n = 1'b1;
    rst_chk();
    wrap_up();
  end
endmodule : tb
`default_nettype wire
